// ---- hdl/acpc_map.svh ----
/*
 * Register offsets, field positions, reset values and timing counts for
 * the converter pin configuration block.
 * Assumes an 8-bit APB byte address and 32-bit data, one word per register.
 */
//
// Contract
// - Four-bit pin config field picks analog or digital role per pin.
// - Pin role comes from control register two alone; direction bits do not alter it.
// - Result registers are not touched by reset; undefined until converted.
// - A selected pin driven as output converts its digital output level.
// - Channel select and direction bits never gate or block conversion.
// - First and fifth port reads return zero on analog input pins.
// - Second port reads return one on analog input pins.
// - Digital input pins still feed their analog level when selected.
// - Setting go starts conversion; go clears after thirteen TAD periods.
`ifndef ACPC_MAP_SVH
`define ACPC_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define ACPC_OFF_CTRL_ONE     8'h00
`define ACPC_OFF_CTRL_TWO     8'h04
`define ACPC_OFF_RES_HIGH     8'h08
`define ACPC_OFF_RES_LOW      8'h0c
`define ACPC_OFF_DIR          8'h10
`define ACPC_OFF_DRIVE        8'h14
`define ACPC_OFF_FIRST_IO     8'h18
`define ACPC_OFF_SECOND_IO    8'h1c
`define ACPC_OFF_FIFTH_IO     8'h20

// ****************************************************************
// Field positions
// ****************************************************************
`define ACPC_ON_BIT           0
`define ACPC_GO_BIT           1
`define ACPC_CHAN_LSB         2
`define ACPC_CHAN_MSB         5
`define ACPC_CLK_LSB          6
`define ACPC_CLK_MSB          7
`define ACPC_PCFG_MSB         3
`define ACPC_RES_SPLIT        8

// ****************************************************************
// Reset values and timing counts
// ****************************************************************
`define ACPC_DIR_RESET        10'h3ff
`define ACPC_DRIVE_RESET      10'h000
`define ACPC_TAD_TOTAL        4'hd
`define ACPC_DIV_2            6'h01
`define ACPC_DIV_8            6'h07
`define ACPC_DIV_32           6'h1f
`define ACPC_DIV_64           6'h3f
`define ACPC_FIRST_PINS       5
`define ACPC_FIFTH_PINS       3
`define ACPC_SECOND_PINS      2

`endif

// ---- hdl/acpc_pkg.sv ----
/*
 * Types shared by the converter pin configuration block.
 * Assumes the map header supplies all numeric constants.
 */
package acpc_pkg;
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SETTLE,
      ST_TRIAL
   } acpc_state_t;

   typedef logic [11:0] acpc_code_t;
endpackage

// ---- hdl/acpc_top.sv ----
/*
 * APB register slave and successive-approximation sequencer for a 12-bit
 * converter, with per-pin analog/digital selection and port read masking.
 * Assumes an external analog front end that compares the selected channel
 * against sar_trial and answers on cmp_in within one TAD period, and port
 * pin inputs already synchronous to sys_clk.
 */
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ps
`include "acpc_map.svh"

module acpc_top #(
   parameter int N_PINS = 10
) (
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [9:0]  pin_in,
   output logic      [9:0]  pin_out,
   output logic      [9:0]  pin_oe,
   input  wire logic [7:0]  first_port_in,
   input  wire logic [7:0]  second_port_in,
   input  wire logic [7:0]  fifth_port_in,
   input  wire logic        cmp_in,
   output logic      [3:0]  sar_channel,
   output logic      [11:0] sar_trial,
   output logic             sar_sample
);

   // ****************************************************************
   // Elaboration check
   // ****************************************************************
   // The pin maps below are laid out for exactly ten analog pins.
   generate
      if (N_PINS != 10) begin : g_bad_pins
         $error("acpc_top serves exactly ten analog pins");
      end
   endgenerate

   // ****************************************************************
   // Functions
   // ****************************************************************
   // Config code n makes pins 0 to 9-n analog; codes above nine none.
   function automatic logic [9:0] analog_mask(input logic [3:0] code);
      logic [9:0] m;
      m = 10'h000;
      for (int i = 0; i < 10; i++) begin
         if (int'(code) + i < 10) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   // Terminal count of the TAD divider for each clock select code.
   function automatic logic [5:0] tad_term(input logic [1:0] sel);
      logic [5:0] t;
      case (sel)
         2'h0:    t = `ACPC_DIV_2;
         2'h1:    t = `ACPC_DIV_8;
         2'h2:    t = `ACPC_DIV_32;
         default: t = `ACPC_DIV_64;
      endcase
      return t;
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   logic                 conv_on;
   logic                 go;
   logic [3:0]           chan;
   logic [1:0]           clk_sel;
   logic [3:0]           pcfg;
   logic [9:0]           dir;
   logic [9:0]           drive;
   acpc_pkg::acpc_state_t state;
   logic [5:0]           div_cnt;
   logic [3:0]           tad_cnt;
   logic [11:0]          acc;
   logic [11:0]          bit_mask;
   acpc_pkg::acpc_code_t result;

   logic                 next_conv_on;
   logic                 next_go;
   logic [3:0]           next_chan;
   logic [1:0]           next_clk_sel;
   logic [3:0]           next_pcfg;
   logic [9:0]           next_dir;
   logic [9:0]           next_drive;
   acpc_pkg::acpc_state_t next_state;
   logic [5:0]           next_div_cnt;
   logic [3:0]           next_tad_cnt;
   logic [11:0]          next_acc;
   logic [11:0]          next_bit_mask;
   logic [11:0]          next_sar_trial;
   logic                 next_sar_sample;
   logic                 res_load;
   logic [31:0]          next_prdata;
   logic                 next_pready;
   logic                 next_pslverr;

   logic                 wr_fire;
   logic                 wr_ctrl1;
   logic [9:0]           amask;
   logic                 tad_tick;
   logic                 cmp_eff;
   logic                 sel_valid;
   logic [7:0]           first_rd;
   logic [7:0]           second_rd;
   logic [7:0]           fifth_rd;

   // ****************************************************************
   // Decode and pin roles
   // ****************************************************************
   // A write takes effect only at the edge that completes the access.
   assign wr_fire  = psel & penable & pready & pwrite;
   assign wr_ctrl1 = wr_fire & (paddr == `ACPC_OFF_CTRL_ONE);
   assign amask    = analog_mask(pcfg);
   assign tad_tick = (state != acpc_pkg::ST_IDLE) &&
                     (div_cnt == tad_term(clk_sel));
   assign sel_valid = (chan < 4'ha);

   // A driven pin presents its own output level to the converter, so a
   // high drive reads full scale and a low drive reads zero.
   always_comb begin
      cmp_eff = cmp_in;
      if (sel_valid && pin_oe[chan]) begin
         cmp_eff = pin_out[chan];
      end
   end

   // Analog pins read low on the first and fifth ports, high on the second.
   always_comb begin
      first_rd  = first_port_in;
      second_rd = second_port_in;
      fifth_rd  = fifth_port_in;
      for (int i = 0; i < `ACPC_FIRST_PINS; i++) begin
         if (amask[i]) begin
            first_rd[i] = 1'b0;
         end
      end
      for (int i = 0; i < `ACPC_FIFTH_PINS; i++) begin
         if (amask[i + `ACPC_FIRST_PINS]) begin
            fifth_rd[i] = 1'b0;
         end
      end
      for (int i = 0; i < `ACPC_SECOND_PINS; i++) begin
         if (amask[i + `ACPC_FIRST_PINS + `ACPC_FIFTH_PINS]) begin
            second_rd[i] = 1'b1;
         end
      end
   end

   // ****************************************************************
   // Control registers and conversion sequencer
   // ****************************************************************
   // Start, abort and completion share one process so that the go bit has
   // a single owner; a software set in the completion cycle wins.
   always_comb begin
      next_conv_on    = conv_on;
      next_go         = go;
      next_chan       = chan;
      next_clk_sel    = clk_sel;
      next_pcfg       = pcfg;
      next_dir        = dir;
      next_drive      = drive;
      next_state      = state;
      next_div_cnt    = div_cnt;
      next_tad_cnt    = tad_cnt;
      next_acc        = acc;
      next_bit_mask   = bit_mask;
      next_sar_trial  = sar_trial;
      next_sar_sample = 1'b0;
      res_load        = 1'b0;
      if (state != acpc_pkg::ST_IDLE) begin
         next_div_cnt = tad_tick ? 6'h00 : div_cnt + 6'h01;
      end
      case (state)
         acpc_pkg::ST_IDLE: begin
            next_div_cnt = 6'h00;
         end
         acpc_pkg::ST_SETTLE: begin
            next_sar_sample = ~tad_tick;
            if (tad_tick) begin
               next_state     = acpc_pkg::ST_TRIAL;
               next_tad_cnt   = tad_cnt + 4'h1;
               next_sar_trial = acc | bit_mask;
            end
         end
         acpc_pkg::ST_TRIAL: begin
            if (tad_tick) begin
               next_acc       = cmp_eff ? (acc | bit_mask) : acc;
               next_bit_mask  = bit_mask >> 1;
               next_tad_cnt   = tad_cnt + 4'h1;
               next_sar_trial = next_acc | next_bit_mask;
               if (tad_cnt == `ACPC_TAD_TOTAL - 4'h1) begin
                  next_state = acpc_pkg::ST_IDLE;
                  next_go    = 1'b0;
                  res_load   = 1'b1;
               end
            end
         end
         default: begin
            next_state = acpc_pkg::ST_IDLE;
         end
      endcase
      if (wr_ctrl1) begin
         next_conv_on = pwdata[`ACPC_ON_BIT];
         next_chan    = pwdata[`ACPC_CHAN_MSB:`ACPC_CHAN_LSB];
         next_clk_sel = pwdata[`ACPC_CLK_MSB:`ACPC_CLK_LSB];
         next_go      = pwdata[`ACPC_GO_BIT];
         // Turning on and setting go together leaves go cleared.
         if (pwdata[`ACPC_ON_BIT] && !conv_on) begin
            next_go = 1'b0;
         end
      end
      if (wr_fire && paddr == `ACPC_OFF_CTRL_TWO) begin
         next_pcfg = pwdata[`ACPC_PCFG_MSB:0];
      end
      if (wr_fire && paddr == `ACPC_OFF_DIR) begin
         next_dir = pwdata[9:0];
      end
      if (wr_fire && paddr == `ACPC_OFF_DRIVE) begin
         next_drive = pwdata[9:0];
      end
      // Clearing go or the enable mid-conversion aborts and keeps the
      // partial value, which software can still read back.
      if (state != acpc_pkg::ST_IDLE && (!next_go || !next_conv_on)) begin
         next_state = acpc_pkg::ST_IDLE;
         next_go    = 1'b0;
         res_load   = 1'b1;
      end
      // Neither channel nor direction is consulted here. Starting from
      // idle also serves a go set in the completion cycle, so a set that
      // wins over the hardware clear never leaves go stuck with no work.
      if (next_go && next_conv_on &&
          next_state == acpc_pkg::ST_IDLE) begin
         next_state     = acpc_pkg::ST_SETTLE;
         next_div_cnt   = 6'h00;
         next_tad_cnt   = 4'h0;
         next_acc       = 12'h000;
         next_bit_mask  = 12'h800;
         next_sar_trial = 12'h000;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         conv_on    <= 1'b0;
         go         <= 1'b0;
         chan       <= 4'h0;
         clk_sel    <= 2'h0;
         pcfg       <= 4'h0;
         dir        <= `ACPC_DIR_RESET;
         drive      <= `ACPC_DRIVE_RESET;
         state      <= acpc_pkg::ST_IDLE;
         div_cnt    <= 6'h00;
         tad_cnt    <= 4'h0;
         acc        <= 12'h000;
         bit_mask   <= 12'h800;
         sar_trial  <= 12'h000;
         sar_sample <= 1'b0;
         sar_channel <= 4'h0;
         pin_out    <= 10'h000;
         pin_oe     <= 10'h000;
      end else begin
         conv_on    <= next_conv_on;
         go         <= next_go;
         chan       <= next_chan;
         clk_sel    <= next_clk_sel;
         pcfg       <= next_pcfg;
         dir        <= next_dir;
         drive      <= next_drive;
         state      <= next_state;
         div_cnt    <= next_div_cnt;
         tad_cnt    <= next_tad_cnt;
         acc        <= next_acc;
         bit_mask   <= next_bit_mask;
         sar_trial  <= next_sar_trial;
         sar_sample <= next_sar_sample;
         sar_channel <= next_chan;
         pin_out    <= next_drive;
         pin_oe     <= ~next_dir;
      end
   end

   // Results have no reset on purpose: they keep whatever they held.
   always_ff @(posedge sys_clk) begin
      if (res_load) begin
         result <= next_acc;
      end
   end

   // ****************************************************************
   // APB read path
   // ****************************************************************
   // One wait state: pready rises in the second access cycle.
   always_comb begin
      next_pready  = psel & penable & ~pready;
      next_pslverr = 1'b0;
      next_prdata  = 32'h0000_0000;
      if (next_pready) begin
         case (paddr)
            `ACPC_OFF_CTRL_ONE: begin
               next_prdata[`ACPC_ON_BIT] = conv_on;
               next_prdata[`ACPC_GO_BIT] = go;
               next_prdata[`ACPC_CHAN_MSB:`ACPC_CHAN_LSB] = chan;
               next_prdata[`ACPC_CLK_MSB:`ACPC_CLK_LSB]   = clk_sel;
            end
            `ACPC_OFF_CTRL_TWO: next_prdata[`ACPC_PCFG_MSB:0] = pcfg;
            `ACPC_OFF_RES_HIGH: begin
               next_prdata[3:0] = result[11:`ACPC_RES_SPLIT];
            end
            `ACPC_OFF_RES_LOW: begin
               next_prdata[7:0] = result[`ACPC_RES_SPLIT-1:0];
            end
            `ACPC_OFF_DIR:       next_prdata[9:0] = dir;
            `ACPC_OFF_DRIVE:     next_prdata[9:0] = drive;
            `ACPC_OFF_FIRST_IO:  next_prdata[7:0] = first_rd;
            `ACPC_OFF_SECOND_IO: next_prdata[7:0] = second_rd;
            `ACPC_OFF_FIFTH_IO:  next_prdata[7:0] = fifth_rd;
            default: begin
               next_pslverr = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
      end
   end

endmodule

// ---- tb/acpc_assertions.sv ----
/* Port checker for acpc_top, attached by bind at the foot of this file.
   Assumes it sees only the top ports and that the APB master holds
   address and data until pready. */
`timescale 1ns/1ps
`include "acpc_map.svh"
module acpc_checker (
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [9:0]  pin_oe,
   input wire logic [11:0] sar_trial,
   input wire logic        sar_sample
);
   // ************************************************************
   // Shadows of accepted settings
   // ************************************************************
   logic [3:0] pcfg_sh;
   logic [9:0] dir_sh;
   logic       dir_wr;
   logic       wr_ok;
   logic       rd_ok;
   assign wr_ok = pready && pwrite && !pslverr;
   assign rd_ok = pready && !pwrite;
   // The registers are hidden, so accepted writes are mirrored here.
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pcfg_sh <= 4'h0;
         dir_sh  <= 10'h3ff;
         dir_wr  <= 1'b0;
      end else begin
         dir_wr <= wr_ok && (paddr == `ACPC_OFF_DIR);
         if (wr_ok && (paddr == `ACPC_OFF_CTRL_TWO)) pcfg_sh <= pwdata[3:0];
         if (wr_ok && (paddr == `ACPC_OFF_DIR)) dir_sh <= pwdata[9:0];
      end
   end
   // ************************************************************
   // Properties
   // ************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   sequence setup_s; psel && !penable; endsequence
   sequence access_s; psel && penable; endsequence
   ready_wait_a: assert property (setup_s ##1 access_s |=> pready)
      else $error("pready not in second access cycle");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer cycle");
   err_decode_a: assert property (pready |->
      pslverr == (paddr > `ACPC_OFF_FIFTH_IO || paddr[1:0] != 2'h0))
      else $error("error response does not match address");
   dir_oe_a: assert property (dir_wr |-> ##[0:1] pin_oe == ~dir_sh)
      else $error("pin drive enable does not follow direction");
   first_mask_a: assert property (rd_ok && paddr == `ACPC_OFF_FIRST_IO
      && pcfg_sh == 4'h0 |-> prdata[4:0] == 5'h00)
      else $error("analog pin read not zero");
   second_mask_a: assert property (rd_ok && paddr == `ACPC_OFF_SECOND_IO
      && pcfg_sh == 4'h0 |-> prdata[1:0] == 2'h3)
      else $error("analog pin read not one");
   // An abort inside the settle period would also end the sample pulse.
   trial_start_a: assert property ($fell(sar_sample) |->
      ##[0:1] sar_trial == 12'h800)
      else $error("first trial is not the top bit");
endmodule
bind acpc_top acpc_checker chk (.sys_clk(sys_clk), .nrst(nrst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pin_oe(pin_oe), .sar_trial(sar_trial), .sar_sample(sar_sample));

// ---- tb/tb_adc_port_pin_config.sv ----
/* Self-checking bench for acpc_top: APB master, comparator front end and
   expected port values computed from the pin role map.
   Assumes acpc_map.svh is on the include path. */
`timescale 1ns/1ps
`include "acpc_map.svh"
module tb_adc_port_pin_config;
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [7:0]  p1 = 8'h00;
   logic [7:0]  p2 = 8'h00;
   logic [7:0]  p5 = 8'h00;
   logic        cmp_in = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [9:0]  pin_out;
   logic [9:0]  pin_oe;
   logic [11:0] sar_trial;
   logic [3:0]  sar_chan;
   logic [31:0] rd;
   logic        err;
   int          bad_count = 0;
   int          total_checks = 0;
   int          level = 0;
   int          c;
   acpc_top uut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_in(10'h000), .pin_out(pin_out), .pin_oe(pin_oe),
      .first_port_in(p1), .second_port_in(p2), .fifth_port_in(p5),
      .cmp_in(cmp_in), .sar_channel(sar_chan), .sar_trial(sar_trial),
      .sar_sample());
   // Clock of 100 MHz.
   always #5 sys_clk = ~sys_clk;
   // Front end answers one cycle after each new trial, inside one TAD.
   always @(posedge sys_clk) cmp_in <= (level >= int'(sar_trial));
   // ************************************************************
   // Shared tasks and the reference model
   // ************************************************************
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One APB transfer; waits for pready under a bound, never a fixed count.
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      // Look at pready mid-cycle, where it stands settled; the next rising
      // edge is the one that samples it high and completes the transfer.
      do begin
         @(negedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 40);
      if (n >= 40) begin
         bad_count++;
         end_of_test();
      end
      rd = prdata;
      err = pslverr;
      @(posedge sys_clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Pin p is analog when p + pcfg <= 9; masks the matching port bit.
   function automatic logic [31:0] port_exp(input logic [7:0] a,
                                            input int n, input logic [7:0] v);
      logic [7:0] r;
      r = v;
      for (int p = 0; p < 10; p++) begin
         if (p + n <= 9) begin
            if (p < 5 && a == `ACPC_OFF_FIRST_IO) r[p] = 1'b0;
            if (p >= 5 && p < 8 && a == `ACPC_OFF_FIFTH_IO) r[p-5] = 1'b0;
            if (p >= 8 && a == `ACPC_OFF_SECOND_IO) r[p-8] = 1'b1;
         end
      end
      return {24'h0, r};
   endfunction
   // Acquire, start, check go before and after 13 TAD, read the result.
   task automatic convert(input int cs, input int ch, input int exp);
      int t;
      logic [31:0] w;
      t = (cs == 0) ? 2 : (cs == 1) ? 8 : (cs == 2) ? 32 : 64;
      w = {24'h0, 2'(cs), 4'(ch), 2'b01};
      apb(1'b1, `ACPC_OFF_CTRL_ONE, w);
      repeat (3 * t) @(posedge sys_clk);
      chk("channel", 32'(ch), 32'(sar_chan));
      apb(1'b1, `ACPC_OFF_CTRL_ONE, w | 32'h2);
      repeat (13 * t - 4) @(posedge sys_clk);
      apb(1'b0, `ACPC_OFF_CTRL_ONE, 32'h0);
      chk("go busy", 32'h1, 32'(rd[1]));
      apb(1'b0, `ACPC_OFF_CTRL_ONE, 32'h0);
      chk("go done", 32'h0, 32'(rd[1]));
      apb(1'b0, `ACPC_OFF_RES_HIGH, 32'h0);
      chk("result high", 32'(exp >> 8), rd);
      apb(1'b0, `ACPC_OFF_RES_LOW, 32'h0);
      chk("result low", 32'(exp & 255), rd);
   endtask
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      void'($urandom(32'h6134cd75));
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      apb(1'b0, `ACPC_OFF_DIR, 32'h0);
      chk("dir reset", 32'h3ff, rd);
      apb(1'b0, `ACPC_OFF_DRIVE, 32'h0);
      chk("drive reset", 32'h0, rd);
      apb(1'b0, `ACPC_OFF_CTRL_TWO, 32'h0);
      chk("pcfg reset", 32'h0, rd);
      apb(1'b1, 8'h24, 32'hffffffff);
      chk("unmapped write err", 32'h1, 32'(err));
      apb(1'b0, 8'h24, 32'h0);
      chk("unmapped read", 32'h0, rd);
      $display("test registers done");
      // Every pin configuration code against the three port reads.
      for (int n = 0; n < 16; n++) begin
         p1 <= 8'($urandom);
         p2 <= 8'($urandom);
         p5 <= 8'($urandom);
         apb(1'b1, `ACPC_OFF_CTRL_TWO, 32'(n));
         apb(1'b0, `ACPC_OFF_FIRST_IO, 32'h0);
         chk("first port", port_exp(`ACPC_OFF_FIRST_IO, n, p1), rd);
         apb(1'b0, `ACPC_OFF_FIFTH_IO, 32'h0);
         chk("fifth port", port_exp(`ACPC_OFF_FIFTH_IO, n, p5), rd);
         apb(1'b0, `ACPC_OFF_SECOND_IO, 32'h0);
         chk("second port", port_exp(`ACPC_OFF_SECOND_IO, n, p2), rd);
      end
      $display("test pin roles done");
      // All pins digital now: conversion must still follow the level.
      for (int cs = 0; cs < 4; cs++) begin
         level = $urandom_range(4095);
         convert(cs, $urandom_range(15), level);
      end
      $display("test conversion timing done");
      // A driven pin converts its own output level.
      c = $urandom_range(9);
      for (int b = 0; b < 2; b++) begin
         apb(1'b1, `ACPC_OFF_DIR, 32'h3ff & ~(32'h1 << c));
         apb(1'b1, `ACPC_OFF_DRIVE, 32'(b) << c);
         // The drive level lands at the completing edge; look mid-cycle.
         @(negedge sys_clk);
         chk("pin enable", 32'(10'h1 << c), 32'(pin_oe));
         chk("pin level", 32'(b) << c, 32'(pin_out));
         convert(0, c, b * 4095);
      end
      $display("test driven pin done");
      // A reset in mid-run leaves the result alone.
      nrst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      apb(1'b0, `ACPC_OFF_RES_HIGH, 32'h0);
      chk("result kept high", 32'hf, rd);
      apb(1'b0, `ACPC_OFF_RES_LOW, 32'h0);
      chk("result kept low", 32'hff, rd);
      apb(1'b0, `ACPC_OFF_DIR, 32'h0);
      chk("dir after reset", 32'h3ff, rd);
      $display("test reset keep done");
      end_of_test();
   end
endmodule
